/* lcd_ext_cmd_cursor_font.sv */
/*
 extended command decoder: cursor auto-move, font bank select, data
 access with pointer stepping. assumes host strobes are one-cycle pulses
 synchronous to clk_i, operand bytes precede the command byte.
*/
`timescale 1ns/1ps
`include "lcd_ext_consts.svh"

// Function
// R1: host writes two operand bytes before the auto-move command byte.
// R2: second operand byte is ignored for auto-move and font select.
// R3: auto-move enable follows first operand bit 0; other bits ignored.
// R4: when auto-move enabled, cursor steps with every data write or read.
// R5: command 70h selects font bank from first operand bits 1..0.
// R6: field 10 first bank, 11 second bank; 00 and 01 no selection.
// R7: reset disables auto-move, default font; settings hold until reissued.
// R8: auto-move steps the cursor pointer loaded by cursor set.
// R9: data write with increment stores at address pointer then increments.
module lcd_ext_cmd_cursor_font #(
   parameter int ADDR_W = 16
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              data_wr_i,
   input  wire logic              cmd_wr_i,
   input  wire logic [7:0]        bus_i,
   output logic                   auto_move_o,
   output logic [1:0]             font_bank_o,
   output logic [ADDR_W-1:0]      cursor_ptr_o,
   output logic [ADDR_W-1:0]      display_addr_pointer_o,
   output logic                   mem_wr_o,
   output logic                   mem_rd_o,
   output logic [ADDR_W-1:0]      mem_addr_o,
   output logic [7:0]             mem_data_o
);
   lcd_ext_pkg::opnd_state_e st_q, st_d;
   logic [7:0]        first_operand_q, first_operand_d;
   logic [7:0]        second_operand_q, second_operand_d;
   logic              auto_q, auto_d;
   logic [1:0]        font_q, font_d;
   logic              wr_q, wr_d, rd_q, rd_d;
   logic [ADDR_W-1:0] maddr_q, maddr_d;
   logic [7:0]        mdata_q, mdata_d;
   logic              aptr_load, aptr_inc, aptr_dec;
   logic              cur_load, cur_inc, cur_dec;
   logic              access;
   logic              step_up;
   logic [ADDR_W-1:0] aptr;
   logic [ADDR_W-1:0] operand_word;

   assign operand_word = ADDR_W'({second_operand_q, first_operand_q});

   // operand stack and command decode
   always_comb begin
      st_d             = st_q;
      first_operand_d  = first_operand_q;
      second_operand_d = second_operand_q;
      auto_d           = auto_q;
      font_d           = font_q;
      wr_d             = 1'b0;
      rd_d             = 1'b0;
      maddr_d          = maddr_q;
      mdata_d          = mdata_q;
      aptr_load        = 1'b0;
      aptr_inc         = 1'b0;
      aptr_dec         = 1'b0;
      cur_load         = 1'b0;
      access           = 1'b0;
      step_up          = 1'b0;
      if (data_wr_i) begin
         // operands land in order; a third byte overwrites the second
         case (st_q)
            lcd_ext_pkg::ST_OP0: begin
               first_operand_d = bus_i;
               st_d            = lcd_ext_pkg::ST_OP1;
            end
            lcd_ext_pkg::ST_OP1, lcd_ext_pkg::ST_OP2: begin
               second_operand_d = bus_i;
               st_d             = lcd_ext_pkg::ST_OP2;
            end
            default: st_d = lcd_ext_pkg::ST_OP0;
         endcase
      end else if (cmd_wr_i) begin
         st_d = lcd_ext_pkg::ST_OP0; // R1
         case (bus_i)
            `CMD_AUTO_MOVE: begin
               auto_d = first_operand_q[`AUTO_MOVE_BIT]; // R3 R2
            end
            `CMD_FONT_SELECT: begin
               // R5 R6 R2
               case (first_operand_q[`FONT_SEL_HI:`FONT_SEL_LO])
                  2'h2:    font_d = `FONT_BANK_FIRST;
                  2'h3:    font_d = `FONT_BANK_SECOND;
                  default: font_d = font_q;
               endcase
            end
            `CMD_CURSOR_SET: begin
               cur_load = 1'b1; // R8
            end
            `CMD_DATA_WR_INC, `CMD_DATA_WR_DEC, `CMD_DATA_WR_KEEP: begin
               wr_d     = 1'b1; // R9
               maddr_d  = aptr;
               mdata_d  = first_operand_q;
               access   = 1'b1;
               aptr_inc = (bus_i == `CMD_DATA_WR_INC); // R9
               aptr_dec = (bus_i == `CMD_DATA_WR_DEC);
               step_up  = (bus_i != `CMD_DATA_WR_DEC);
            end
            `CMD_DATA_RD_INC, `CMD_DATA_RD_DEC, `CMD_DATA_RD_KEEP: begin
               rd_d     = 1'b1;
               maddr_d  = aptr;
               access   = 1'b1;
               aptr_inc = (bus_i == `CMD_DATA_RD_INC);
               aptr_dec = (bus_i == `CMD_DATA_RD_DEC);
               step_up  = (bus_i != `CMD_DATA_RD_DEC);
            end
            `CMD_ADDR_SET_LOCAL: begin
               aptr_load = 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   // cursor steps down on decrement accesses and up on all other data accesses while auto-move is on
   assign cur_inc = access & auto_q & step_up;  // R4
   assign cur_dec = access & auto_q & ~step_up; // R4

   // state registers; reset values give auto-move off and default font
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q             <= lcd_ext_pkg::ST_OP0;
         first_operand_q  <= 8'h00;
         second_operand_q <= 8'h00;
         auto_q           <= `AUTO_MOVE_RST;     // R7
         font_q           <= `FONT_BANK_DEFAULT; // R7
         wr_q             <= 1'b0;
         rd_q             <= 1'b0;
         maddr_q          <= '0;
         mdata_q          <= 8'h00;
      end else begin
         st_q             <= st_d;
         first_operand_q  <= first_operand_d;
         second_operand_q <= second_operand_d;
         auto_q           <= auto_d;
         font_q           <= font_d;
         wr_q             <= wr_d;
         rd_q             <= rd_d;
         maddr_q          <= maddr_d;
         mdata_q          <= mdata_d;
      end
   end

   ptr_step #(.WIDTH(ADDR_W)) u_addr_ptr (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .load_i     (aptr_load),
      .load_val_i (operand_word),
      .inc_i      (aptr_inc),
      .dec_i      (aptr_dec),
      .ptr_o      (aptr)
   );

   ptr_step #(.WIDTH(ADDR_W)) u_cursor (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .load_i     (cur_load),
      .load_val_i (operand_word),
      .inc_i      (cur_inc),
      .dec_i      (cur_dec),
      .ptr_o      (cursor_ptr_o)
   );

   assign auto_move_o            = auto_q;
   assign font_bank_o            = font_q;
   assign display_addr_pointer_o = aptr;
   assign mem_wr_o               = wr_q;
   assign mem_rd_o               = rd_q;
   assign mem_addr_o             = maddr_q;
   assign mem_data_o             = mdata_q;

   // auto-move setting tracks operand bit 0 one cycle after the command
   a_auto_move_set: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr_i && !data_wr_i && bus_i == `CMD_AUTO_MOVE
      |=> auto_move_o == $past(first_operand_q[0]))
      else $error("auto-move setting wrong");  // R3

   // second operand never changes auto-move outcome
   a_second_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr_i && !data_wr_i && bus_i == `CMD_AUTO_MOVE && first_operand_q[0]
      |=> auto_move_o)
      else $error("second operand affected auto-move");  // R2

   // cursor steps up by one with each write-increment access when enabled
   a_cursor_step: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr_i && !data_wr_i && bus_i == `CMD_DATA_WR_INC && auto_move_o
      |=> cursor_ptr_o == $past(cursor_ptr_o) + ADDR_W'(1))
      else $error("cursor did not step");  // R4

   // cursor stands still when auto-move disabled, except on cursor set
   a_cursor_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !auto_move_o && !(cmd_wr_i && bus_i == `CMD_CURSOR_SET)
      |=> $stable(cursor_ptr_o))
      else $error("cursor moved while disabled");  // R4

   // font code 10 picks the first bank
   a_font_first: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr_i && !data_wr_i && bus_i == `CMD_FONT_SELECT
      && first_operand_q[1:0] == 2'h2 |=> font_bank_o == `FONT_BANK_FIRST)
      else $error("first font bank not selected");  // R5

   a_font_keep: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr_i && !data_wr_i && bus_i == `CMD_FONT_SELECT
      && !first_operand_q[1] |=> $stable(font_bank_o))
      else $error("font changed on no-select code");  // R6

   // settings hold without a new command
   a_setting_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !cmd_wr_i |=> $stable(auto_move_o) && $stable(font_bank_o))
      else $error("setting changed without command");  // R7

   // data write stores at pointer then pointer increments
   a_write_inc: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr_i && !data_wr_i && bus_i == `CMD_DATA_WR_INC
      |=> mem_wr_o && mem_addr_o == $past(aptr)
      && display_addr_pointer_o == $past(aptr) + ADDR_W'(1))
      else $error("write increment wrong");  // R9

   // cursor set loads the operand word
   a_cursor_load: assert property (@(posedge clk_i) disable iff (rst_i)
      cmd_wr_i && !data_wr_i && bus_i == `CMD_CURSOR_SET
      |=> cursor_ptr_o == $past(operand_word))
      else $error("cursor load wrong");  // R8
endmodule : lcd_ext_cmd_cursor_font

/* lcd_ext_consts.svh */
/*
 command codes, operand field positions and reset values of the extended
 command decoder. assumes inclusion by bare name from design files.
*/
`ifndef LCD_EXT_CONSTS_SVH
`define LCD_EXT_CONSTS_SVH

`define CMD_AUTO_MOVE      8'h60
`define CMD_FONT_SELECT    8'h70
`define CMD_DATA_WR_INC    8'hc0
`define CMD_DATA_RD_INC    8'hc1
`define CMD_DATA_WR_DEC    8'hc2
`define CMD_DATA_RD_DEC    8'hc3
`define CMD_DATA_WR_KEEP   8'hc4
`define CMD_DATA_RD_KEEP   8'hc5
`define CMD_CURSOR_SET     8'h21
`define CMD_ADDR_SET_LOCAL 8'h24
`define AUTO_MOVE_BIT      0
`define FONT_SEL_HI        1
`define FONT_SEL_LO        0
`define FONT_BANK_DEFAULT  2'h0
`define FONT_BANK_FIRST    2'h1
`define FONT_BANK_SECOND   2'h2
`define AUTO_MOVE_RST      1'b0

`endif

/* lcd_ext_pkg.sv */
/*
 types shared by the extended command decoder.
 assumes nothing of its surroundings.
*/
package lcd_ext_pkg;
   typedef enum logic [1:0] {
      ST_OP0  = 2'b00,
      ST_OP1  = 2'b01,
      ST_OP2  = 2'b11
   } opnd_state_e;
endpackage : lcd_ext_pkg

/* ptr_step.sv */
/*
 pointer stepper: loads, increments or decrements a pointer.
 assumes one-cycle load and step strobes from the decoder.
*/
`timescale 1ns/1ps
module ptr_step #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             load_i,
   input  wire logic [WIDTH-1:0] load_val_i,
   input  wire logic             inc_i,
   input  wire logic             dec_i,
   output logic      [WIDTH-1:0] ptr_o
);
   logic [WIDTH-1:0] ptr_d;

   // load beats a step issued in the same cycle
   always_comb begin
      ptr_d = ptr_o;
      if (load_i) begin
         ptr_d = load_val_i;
      end else if (inc_i) begin
         ptr_d = ptr_o + WIDTH'(1);
      end else if (dec_i) begin
         ptr_d = ptr_o - WIDTH'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ptr_o <= '0;
      end else begin
         ptr_o <= ptr_d;
      end
   end
endmodule : ptr_step

/* host_model.sv */
/*
 behavioural host that writes operand and command bytes to the decoder.
 assumes one clock; the bench calls its send task hierarchically.
*/
`timescale 1ns/1ps
module host_model (
   input  wire logic       clk_i,
   output logic            data_wr_o,
   output logic            cmd_wr_o,
   output logic [7:0]      bus_o
);
   initial begin
      data_wr_o = 1'b0;
      cmd_wr_o  = 1'b0;
      bus_o     = 8'h5a;
   end

   // one byte per edge; an idle bus shows the inverse so stale data never passes
   task automatic put(input logic dw, input logic cw, input logic [7:0] b, input int gap);
      data_wr_o <= dw;
      cmd_wr_o  <= cw;
      bus_o     <= b;
      @(posedge clk_i);
      repeat (gap) begin
         data_wr_o <= 1'b0;
         cmd_wr_o  <= 1'b0;
         bus_o     <= ~b;
         @(posedge clk_i);
      end
   endtask : put

   // operands first, command byte last; returns at the edge taking the command
   task automatic send(input logic [7:0] op1, input logic [7:0] op2, input logic [7:0] cmd,
                       input int nops, input int gap);
      @(posedge clk_i);
      if (nops > 0) put(1'b1, 1'b0, op1, gap);
      if (nops > 1) put(1'b1, 1'b0, op2, gap);
      put(1'b0, 1'b1, cmd, 0);
      cmd_wr_o <= 1'b0;
      bus_o    <= ~cmd;
   endtask : send
endmodule : host_model

/* tb_top.sv */
/*
 self-checking bench for the extended command decoder with a host model.
 assumes the answer lands on the edge that takes the command byte.
*/
`timescale 1ns/1ps
`include "lcd_ext_consts.svh"
module tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        data_wr, cmd_wr, auto_mv, mem_wr, mem_rd;
   logic [7:0]  bus, mem_data, op1;
   logic [1:0]  font;
   logic [15:0] cur, addr_ptr, mem_addr, e_cur, e_addr, v, a, old;
   logic [1:0]  e_font;
   logic        e_auto, wr;
   int          fails, comparisons, cycles, sel;

   always #2.5 clk_i = ~clk_i;

   lcd_ext_cmd_cursor_font #(.ADDR_W(16)) i_lcd_ext_cmd_cursor_font (
      .clk_i(clk_i), .rst_i(rst_i), .data_wr_i(data_wr), .cmd_wr_i(cmd_wr), .bus_i(bus),
      .auto_move_o(auto_mv), .font_bank_o(font), .cursor_ptr_o(cur),
      .display_addr_pointer_o(addr_ptr), .mem_wr_o(mem_wr), .mem_rd_o(mem_rd),
      .mem_addr_o(mem_addr), .mem_data_o(mem_data));
   host_model i_host_model (.clk_i(clk_i), .data_wr_o(data_wr), .cmd_wr_o(cmd_wr), .bus_o(bus));

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic stop_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test

   // 10 and 11 pick a bank, the other codes keep the current one
   function automatic logic [1:0] exp_font(input logic [1:0] prev, input logic [1:0] c);
      if (c == 2'h2) return `FONT_BANK_FIRST;
      if (c == 2'h3) return `FONT_BANK_SECOND;
      return prev;
   endfunction : exp_font

   // keep-type accesses still step the cursor upward
   function automatic logic [15:0] step(input logic [15:0] p, input logic [7:0] c, input logic up);
      case (c[2:1])
         2'h0: return p + 16'h1;
         2'h1: return p - 16'h1;
         default: return up ? p + 16'h1 : p;
      endcase
   endfunction : step

   // hang guard well above the expected run length
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         stop_test();
      end
   end

   initial begin
      void'($urandom(87));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("auto", 16'h0, 16'(auto_mv));
      chk("font", 16'h0, 16'(font));
      e_font = `FONT_BANK_DEFAULT;
      // auto-move: only bit 0 of the first operand counts
      for (int i = 0; i < 8; i++) begin
         op1 = (i == 0) ? 8'hfe : (i == 1) ? 8'h01 : 8'($urandom);
         i_host_model.send(op1, 8'($urandom), `CMD_AUTO_MOVE, 2, i % 2);
         #1;
         chk("auto", 16'(op1[0]), 16'(auto_mv));
         chk("font", 16'(e_font), 16'(font));
      end
      e_auto = op1[0];
      // font select over every code, noisy upper bits and second operand
      for (int i = 0; i < 12; i++) begin
         sel = (i * 3) % 4;
         op1 = {6'($urandom), 2'(sel)};
         i_host_model.send(op1, 8'($urandom), `CMD_FONT_SELECT, 2, 0);
         #1;
         e_font = exp_font(e_font, 2'(sel));
         chk("font", 16'(e_font), 16'(font));
         chk("auto", 16'(e_auto), 16'(auto_mv));
      end
      // data accesses with auto-move on, then off
      for (int r = 0; r < 2; r++) begin
         e_auto = (r == 0);
         i_host_model.send({7'($urandom), e_auto}, 8'h00, `CMD_AUTO_MOVE, 2, 0);
         v = (r == 0) ? 16'hffff : 16'($urandom);
         a = (r == 0) ? 16'h0000 : 16'($urandom);
         i_host_model.send(v[7:0], v[15:8], `CMD_CURSOR_SET, 2, 0);
         i_host_model.send(a[7:0], a[15:8], `CMD_ADDR_SET_LOCAL, 2, 1);
         #1;
         e_cur = v;
         e_addr = a;
         chk("cursor", e_cur, cur);
         chk("addr_ptr", e_addr, addr_ptr);
         for (int k = 0; k < 6; k++) begin
            wr = ~k[0];
            op1 = 8'($urandom);
            old = e_addr;
            i_host_model.send(op1, 8'h00, `CMD_DATA_WR_INC + 8'(k), int'(wr), $urandom_range(0, 2));
            #1;
            chk("mem_wr", 16'(wr), 16'(mem_wr));
            chk("mem_rd", 16'(!wr), 16'(mem_rd));
            chk("mem_addr", old, mem_addr);
            if (wr) chk("mem_data", 16'(op1), 16'(mem_data));
            e_addr = step(e_addr, `CMD_DATA_WR_INC + 8'(k), 1'b0);
            if (e_auto) e_cur = step(e_cur, `CMD_DATA_WR_INC + 8'(k), 1'b1);
            chk("addr_ptr", e_addr, addr_ptr);
            chk("cursor", e_cur, cur);
         end
      end
      stop_test();
   end
endmodule : tb_top
